// [common/uart_ext_map.svh]
`ifndef UART_EXT_MAP_SVH
`define UART_EXT_MAP_SVH
// ****************************************
// Offsets
// ****************************************
`define OFS_TRIGGER 3'h0
`define OFS_FEATURE 3'h1
`define OFS_ALTFUNC 3'h2
`define OFS_ADVSPEC 3'h4
`define OFS_SAMPLE 3'h5
`define OFS_SECOND_XOFF_CHAR 3'h7
// ****************************************
// Access keys and reset values
// ****************************************
`define LCR_ENH_KEY 8'hBF
`define LCR_DLAB_BIT 7
`define EFR_ENH_BIT 4
`define FEATURE_RESET 8'h20
`define TRIG_MAX 7'h40
`define TABLE_D 2'h3
`define REVISION_VALUE 8'h01
`define DEVICE_ID_VALUE 8'h5A
`endif

// [common/uart_ext_pkg.sv]
package uart_ext_pkg;
  // Host register port
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } host_req_s;
  // Advanced special register fields
  typedef struct packed {
    logic rs485_access;
    logic tx_disable;
    logic rx_disable;
    logic irda_fast;
    logic irda_rx_invert;
    logic sample_enable;
    logic unused;
    logic ready_disable;
  } adv_special_s;
  typedef struct packed {
    logic [7:0] second_xoff_char;
    logic [6:0] rx_trig;
    logic [6:0] tx_trig;
    logic [1:0] table_sel;
    logic [3:0] hyst_sel;
    logic afr_op2_sel;
    adv_special_s advanced_special;
    logic [7:0] sample_clk;
    logic fc_show_tx;
    logic [7:0] rdata;
    logic rvalid;
    logic op2;
    logic [5:0] hyst;
  } state_s;
endpackage

// [logic/uart_ext_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uart_ext_map.svh"
// Contract
// - Second XOFF at 0x07 when LINE_CONTROL_REG=0xBF
// - Revision read at 0x00, DLAB, divisors zero
// - Device ID under same zero-divisor condition
// - Trigger write bit7 selects RX or TX
// - Low seven bits set table D level
// - Level counter bit7 toggles after reads
// - Bits 6:0 report selected FIFO count
// - Feature bits 5:4 select trigger table
// - Feature bits 3:0 pick hysteresis characters
// - Hysteresis active only with table D
// - Alternate function needs EFR4 clear, DLAB
// - Alt bit1 selects second output source
// - Advanced special needs EFR4 set, DLAB
// - ADVANCED_SPECIAL bit7 enables RS-485 register access
// - ADVANCED_SPECIAL bit6 disables transmitter
// - ADVANCED_SPECIAL bit5 disables receiver
// - ADVANCED_SPECIAL bit4 selects infrared pulse width
// - ADVANCED_SPECIAL bit3 inverts infrared receive input
// - ADVANCED_SPECIAL bit2 enables sample clock register
// - ADVANCED_SPECIAL bit0 disables FIFO ready access
// - Sample clock at 0x05 when ASR2 set
module uart_ext_regs
  import uart_ext_pkg::*;
#(
  parameter logic [7:0] REVISION = `REVISION_VALUE, // arbitrary value
  parameter logic [7:0] DEVICE_ID = `DEVICE_ID_VALUE // arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Host register port
  input wire host_req_s req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  // Core register context
  input wire logic [7:0] line_control_reg_i,
  input wire logic [7:0] enhanced_feature_reg_i,
  input wire logic [7:0] divisor_low_byte_i,
  input wire logic [7:0] divisor_high_byte_i,
  input wire logic [7:0] modem_control_reg_i,
  input wire logic baud_clock_output_i,
  // FIFO fill levels
  input wire logic [6:0] rx_fifo_count_i,
  input wire logic [6:0] tx_fifo_count_i,
  // Configuration to the channel
  output logic [6:0] receive_trigger_level_o,
  output logic [6:0] transmit_trigger_level_o,
  output logic [1:0] trigger_table_o,
  output logic [5:0] rts_hysteresis_o,
  output logic second_user_output_o,
  output logic rs485_access_en_o,
  output logic tx_disable_o,
  output logic rx_disable_o,
  output logic irda_fast_o,
  output logic irda_rx_invert_o,
  output logic sample_clk_en_o,
  output logic fifo_ready_access_dis_o,
  output logic [7:0] sample_clock_reg_o
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [5:0] hyst_chars(input logic [3:0] code);
    unique case (code)
      4'h0: hyst_chars = 6'd0;
      4'h1: hyst_chars = 6'd4;
      4'h2: hyst_chars = 6'd6;
      4'h3: hyst_chars = 6'd8;
      4'h4: hyst_chars = 6'd8;
      4'h5: hyst_chars = 6'd16;
      4'h6: hyst_chars = 6'd24;
      4'h7: hyst_chars = 6'd32;
      4'h8: hyst_chars = 6'd40;
      4'h9: hyst_chars = 6'd44;
      4'hA: hyst_chars = 6'd48;
      4'hB: hyst_chars = 6'd52;
      4'hC: hyst_chars = 6'd12;
      4'hD: hyst_chars = 6'd20;
      4'hE: hyst_chars = 6'd28;
      4'hF: hyst_chars = 6'd36;
    endcase
  endfunction

  // Levels above the table limit are clamped to keep the FIFO sane
  function automatic logic [6:0] clamp_trig(input logic [6:0] v);
    clamp_trig = (v > `TRIG_MAX) ? `TRIG_MAX : v;
  endfunction

  state_s state_reg;
  state_s state_next;

  logic enh_mode;
  logic dlab_alt;
  logic div_zero;
  logic afr_sel;
  logic asr_sel;
  logic snr_sel;

  always_comb begin
    enh_mode = (line_control_reg_i == `LCR_ENH_KEY);
    dlab_alt = line_control_reg_i[`LCR_DLAB_BIT] && !enh_mode;
    div_zero = (divisor_low_byte_i == 8'h00)
      && (divisor_high_byte_i == 8'h00);
    afr_sel = dlab_alt && !enhanced_feature_reg_i[`EFR_ENH_BIT];
    asr_sel = dlab_alt && enhanced_feature_reg_i[`EFR_ENH_BIT];
    snr_sel = dlab_alt && state_reg.advanced_special.sample_enable;
  end

  // ****************************************
  // Register file
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.rdata = 8'h00;
    if (req_i.wr) begin
      unique case (req_i.addr)
        `OFS_TRIGGER: begin
          if (enh_mode) begin
            if (req_i.wdata[7]) begin
              state_next.tx_trig = clamp_trig(req_i.wdata[6:0]);
            end else begin
              state_next.rx_trig = clamp_trig(req_i.wdata[6:0]);
            end
          end
        end
        `OFS_FEATURE: begin
          if (enh_mode) begin
            state_next.table_sel = req_i.wdata[5:4];
            state_next.hyst_sel = req_i.wdata[3:0];
          end
        end
        `OFS_ALTFUNC: begin
          if (afr_sel) begin
            state_next.afr_op2_sel = req_i.wdata[1];
          end
        end
        `OFS_ADVSPEC: begin
          if (asr_sel) begin
            state_next.advanced_special = adv_special_s'(req_i.wdata);
          end
        end
        `OFS_SAMPLE: begin
          if (snr_sel) begin
            state_next.sample_clk = req_i.wdata;
          end
        end
        `OFS_SECOND_XOFF_CHAR: begin
          if (enh_mode) begin
            state_next.second_xoff_char = req_i.wdata;
          end
        end
        default: begin
        end
      endcase
    end else if (req_i.rd) begin
      state_next.rvalid = 1'b1;
      unique case (req_i.addr)
        `OFS_TRIGGER: begin
          if (enh_mode) begin
            state_next.rdata = {state_reg.fc_show_tx,
              state_reg.fc_show_tx ? tx_fifo_count_i
                                   : rx_fifo_count_i};
            state_next.fc_show_tx = !state_reg.fc_show_tx;
          end else if (line_control_reg_i[`LCR_DLAB_BIT] && div_zero) begin
            state_next.rdata = REVISION;
          end
        end
        `OFS_FEATURE: begin
          if (enh_mode) begin
            state_next.rdata = {2'b00, state_reg.table_sel,
              state_reg.hyst_sel};
          end else if (line_control_reg_i[`LCR_DLAB_BIT] && div_zero) begin
            state_next.rdata = DEVICE_ID;
          end
        end
        `OFS_ALTFUNC: begin
          if (afr_sel) begin
            state_next.rdata = {6'h00, state_reg.afr_op2_sel, 1'b0};
          end
        end
        `OFS_ADVSPEC: begin
          if (asr_sel) begin
            state_next.rdata = state_reg.advanced_special;
          end
        end
        `OFS_SAMPLE: begin
          if (snr_sel) begin
            state_next.rdata = state_reg.sample_clk;
          end
        end
        `OFS_SECOND_XOFF_CHAR: begin
          if (enh_mode) begin
            state_next.rdata = state_reg.second_xoff_char;
          end
        end
        default: begin
        end
      endcase
    end
    // Second output is active low, hence the inversions
    state_next.op2 = state_reg.afr_op2_sel ? !baud_clock_output_i
                                           : !modem_control_reg_i[3];
    // Hysteresis only meaningful with the programmable table
    state_next.hyst = (state_reg.table_sel == `TABLE_D)
      ? hyst_chars(state_reg.hyst_sel) : 6'd0;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
      state_reg.table_sel <= 2'(`FEATURE_RESET >> 4);
      state_reg.op2 <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rdata_o = state_reg.rdata;
  assign rvalid_o = state_reg.rvalid;
  assign receive_trigger_level_o = state_reg.rx_trig;
  assign transmit_trigger_level_o = state_reg.tx_trig;
  assign trigger_table_o = state_reg.table_sel;
  assign rts_hysteresis_o = state_reg.hyst;
  assign second_user_output_o = state_reg.op2;
  assign rs485_access_en_o = state_reg.advanced_special.rs485_access;
  assign tx_disable_o = state_reg.advanced_special.tx_disable;
  assign rx_disable_o = state_reg.advanced_special.rx_disable;
  assign irda_fast_o = state_reg.advanced_special.irda_fast;
  assign irda_rx_invert_o = state_reg.advanced_special.irda_rx_invert;
  assign sample_clk_en_o = state_reg.advanced_special.sample_enable;
  assign fifo_ready_access_dis_o = state_reg.advanced_special.ready_disable;
  assign sample_clock_reg_o = state_reg.sample_clk;

endmodule
`default_nettype wire

// [test/uart_ext_host.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_ext_host
  import uart_ext_pkg::*;
(
  // Bus
  input wire logic clk_sys_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output host_req_s req_o
);
  initial req_o = '0;
  // Gap of idle cycles first, so the host can be slow
  task automatic access(input logic w, input logic [2:0] a,
    input logic [7:0] d, input int gap, output logic [7:0] q,
    output logic ok);
    repeat (gap + 1) @(posedge clk_sys_i);
    req_o <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk_sys_i);
    req_o <= '0;
    #1;
    q = rdata_i;
    ok = rvalid_i === !w;
  endtask
endmodule
`default_nettype wire

// [test/uart_ext_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uart_ext_map.svh"
module uart_ext_regs_bench
  import uart_ext_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  host_req_s req_i;
  logic [7:0] rdata_o, sample_clock_reg_o, q, d;
  logic [7:0] line_control_reg_i, enhanced_feature_reg_i;
  logic [7:0] divisor_low_byte_i, divisor_high_byte_i, modem_control_reg_i;
  logic [6:0] rx_fifo_count_i, tx_fifo_count_i, v;
  logic [6:0] receive_trigger_level_o, transmit_trigger_level_o;
  logic [5:0] rts_hysteresis_o;
  logic [1:0] trigger_table_o;
  logic rvalid_o, baud_clock_output_i, second_user_output_o, ok;
  logic rs485_access_en_o, tx_disable_o, rx_disable_o, irda_fast_o;
  logic irda_rx_invert_o, sample_clk_en_o, fifo_ready_access_dis_o;
  logic [31:0] rnd = 32'h0001458D;
  int miscompares = 0;
  int samples_checked = 0;
  localparam logic [5:0] HY [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08,
    6'h10, 6'h18, 6'h20, 6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C,
    6'h24};
  wire logic [7:0] asr_seen = {rs485_access_en_o, tx_disable_o,
    rx_disable_o, irda_fast_o, irda_rx_invert_o, sample_clk_en_o, 1'b0,
    fifo_ready_access_dis_o};
  uart_ext_regs uart_ext_regs_inst (.*);
  uart_ext_host uart_ext_host_inst (.clk_sys_i(clk_sys_i),
    .rvalid_i(rvalid_o), .rdata_i(rdata_o), .req_o(req_i));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] a,
    input logic [7:0] dw);
    rnd = xs(rnd);
    uart_ext_host_inst.access(w, a, dw, int'(rnd[1:0]), q, ok);
    chk("answer", 8'h01, {7'h00, ok});
  endtask
  // Random FIFO counts, modem bit and baud level per context
  task automatic ctx(input logic [7:0] l, input logic [7:0] e);
    @(posedge clk_sys_i);
    rnd = xs(rnd);
    line_control_reg_i <= l;
    enhanced_feature_reg_i <= e;
    rx_fifo_count_i <= rnd[6:0];
    tx_fifo_count_i <= rnd[14:8];
    baud_clock_output_i <= rnd[16];
    modem_control_reg_i <= rnd[31:24];
  endtask
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {line_control_reg_i, enhanced_feature_reg_i, modem_control_reg_i} = '0;
    {divisor_low_byte_i, divisor_high_byte_i} = '0;
    {rx_fifo_count_i, tx_fifo_count_i, baud_clock_output_i} = '0;
    repeat (20) @(posedge clk_sys_i);
    chk("table_rst", 8'h02, {6'h00, trigger_table_o});
    resetn_i <= 1'b1;
    ctx(8'hBF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, 3'h0, 8'h00);
      d = i[0] ? {1'b1, tx_fifo_count_i} : {1'b0, rx_fifo_count_i};
      chk("fifo_level", d, q);
    end
    for (int i = 0; i < 6; i++) begin
      v = i < 2 ? 7'h40 : (i < 4 ? 7'h00 : {1'b0, rnd[5:0]});
      acc(1'b1, 3'h0, {i[0], v});
      d = {1'b0, i[0] ? transmit_trigger_level_o : receive_trigger_level_o};
      chk("trigger", {1'b0, v}, d);
    end
    d = rnd[15:8];
    acc(1'b1, 3'h7, d);
    acc(1'b0, 3'h7, 8'h00);
    chk("second_xoff_char", d, q);
    foreach (HY[c]) begin
      acc(1'b1, 3'h1, {4'h3, 4'(c)});
      @(posedge clk_sys_i);
      #1;
      chk("hysteresis", {2'h0, HY[c]}, {2'h0, rts_hysteresis_o});
    end
    acc(1'b1, 3'h1, 8'hCF);
    acc(1'b0, 3'h1, 8'h00);
    chk("feature", 8'h0F, q);
    chk("hyst_off", 8'h00, {2'h0, rts_hysteresis_o});
    ctx(8'h80, 8'h00);
    acc(1'b0, 3'h0, 8'h00);
    chk("revision", `REVISION_VALUE, q);
    acc(1'b0, 3'h1, 8'h00);
    chk("device_id", `DEVICE_ID_VALUE, q);
    for (int j = 1; j >= 0; j--) begin
      acc(1'b1, 3'h2, {6'h00, j[0], 1'b0});
      @(posedge clk_sys_i);
      #1;
      d = {7'h00, j[0] ? !baud_clock_output_i : !modem_control_reg_i[3]};
      chk("second_output", d, {7'h00, second_user_output_o});
    end
    ctx(8'h80, 8'h10);
    d = rnd[31:24] | 8'h04;
    acc(1'b1, 3'h4, d);
    chk("advanced", d & 8'hFD, asr_seen);
    acc(1'b0, 3'h4, 8'h00);
    chk("advanced_rd", d, q);
    acc(1'b1, 3'h5, ~d);
    chk("sample_clock", ~d, sample_clock_reg_o);
    ctx(8'h80, 8'h00);
    acc(1'b1, 3'h4, ~d);
    chk("advanced_lock", d & 8'hFD, asr_seen);
    print_verdict();
  end
endmodule
`default_nettype wire

// [test/uart_ext_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module uart_ext_regs_sva
  import uart_ext_pkg::*;
(
  // Host side
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire host_req_s req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  // Context and configuration
  input wire logic [7:0] line_control_reg_i,
  input wire logic [7:0] enhanced_feature_reg_i,
  input wire logic [6:0] rx_fifo_count_i,
  input wire logic [6:0] tx_fifo_count_i,
  input wire logic [6:0] receive_trigger_level_o,
  input wire logic [1:0] trigger_table_o,
  input wire logic [5:0] rts_hysteresis_o,
  input wire logic tx_disable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  wire logic bf = line_control_reg_i == 8'hBF;
  wire logic fcr = bf && req_i.rd && !req_i.wr && req_i.addr == 3'h0;
  wire logic w0 = bf && req_i.wr && req_i.addr == 3'h0;
  wire logic w4 = req_i.wr && req_i.addr == 3'h4;
  wire logic dl = line_control_reg_i[7] && !bf;
  property p_fc;
    fcr |=> rvalid_o && rdata_o[6:0] ==
      (rdata_o[7] ? $past(tx_fifo_count_i) : $past(rx_fifo_count_i));
  endproperty
  a_fc: assert property (p_fc) else $error("fc count");
  property p_tog;
    fcr ##1 !fcr ##1 fcr |=> rdata_o[7] != $past(rdata_o[7], 2);
  endproperty
  a_tog: assert property (p_tog) else $error("fc select");
  property p_rx;
    w0 && !req_i.wdata[7] && req_i.wdata[6:0] <= 7'h40
      |=> receive_trigger_level_o == $past(req_i.wdata[6:0]);
  endproperty
  a_rx: assert property (p_rx) else $error("rx trigger");
  property p_rxk;
    w0 && req_i.wdata[7] |=> $stable(receive_trigger_level_o);
  endproperty
  a_rxk: assert property (p_rxk) else $error("rx trigger hit");
  property p_tbl;
    bf && req_i.wr && req_i.addr == 3'h1
      |=> trigger_table_o == $past(req_i.wdata[5:4]);
  endproperty
  a_tbl: assert property (p_tbl) else $error("table");
  property p_hy;
    trigger_table_o != 2'h3 |=> rts_hysteresis_o == 6'h00;
  endproperty
  a_hy: assert property (p_hy) else $error("hysteresis");
  property p_asr;
    w4 && enhanced_feature_reg_i[4] && dl
      |=> tx_disable_o == $past(req_i.wdata[6]);
  endproperty
  a_asr: assert property (p_asr) else $error("asr write");
  property p_lock;
    w4 && !enhanced_feature_reg_i[4] |=> $stable(tx_disable_o);
  endproperty
  a_lock: assert property (p_lock) else $error("asr open");
  c_tog: cover property (fcr ##1 !fcr ##1 fcr);
  c_asr: cover property (w4 && enhanced_feature_reg_i[4] && dl);
  c_hy: cover property (rts_hysteresis_o == 6'h34);
endmodule
bind uart_ext_regs uart_ext_regs_sva uart_ext_regs_sva_inst (
  .clk_sys_i, .resetn_i, .req_i, .rdata_o, .rvalid_o,
  .line_control_reg_i, .enhanced_feature_reg_i, .rx_fifo_count_i,
  .tx_fifo_count_i, .receive_trigger_level_o, .trigger_table_o,
  .rts_hysteresis_o, .tx_disable_o
);
`default_nettype wire
